// *** seci_device.sv ***
// memory device end: frame decoder, self-timed cycles, storage
`timescale 1ns/10ps
`include "seci_regs.svh"
module seci_device import seci_pkg::*; #(
  parameter int CYCLE_MAX_CYC =
    `SECI_CYCLE_MAX_MS * 1000000 / `SECI_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  seci_link_if.dev link,
  // straps and pins
  input wire logic word_width_strap,
  input wire logic program_allow_pin,
  // state
  output logic busy,
  output logic program_enabled
);
  ////////////////////////////////////////////////////////////////////////
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic sk3_ff;
  logic cs3_ff;
  logic cs_s;
  logic sk_s;
  logic si_s;
  logic x16;
  logic pe_s;
  logic sk_rise;
  logic sk_fall;
  logic cs_fall;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      sk3_ff <= 1'h0;
      cs3_ff <= 1'h0;
    end else begin
      sync1_ff <= {link.chip_select, link.serial_clock, link.serial_in,
                   word_width_strap, program_allow_pin};
      sync2_ff <= sync1_ff;
      sk3_ff <= sync2_ff[3];
      cs3_ff <= sync2_ff[4];
    end
  end
  assign cs_s = sync2_ff[4];
  assign sk_s = sync2_ff[3];
  assign si_s = sync2_ff[2];
  assign x16 = sync2_ff[1];
  assign pe_s = sync2_ff[0];
  assign sk_rise = sk_s & ~sk3_ff;
  assign sk_fall = ~sk_s & sk3_ff;
  assign cs_fall = ~cs_s & cs3_ff;
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:2047];
  seci_dev_st_t st_ff;
  logic [4:0] cnt_ff;
  logic [1:0] opc_ff;
  logic [10:0] addr_ff;
  logic [15:0] data_ff;
  logic pend_ff;
  logic pend_all_ff;
  logic [15:0] pend_data_ff;
  logic prog_en_ff;
  logic busy_ff;
  logic walk_ff;
  logic [10:0] walk_ff_idx;
  logic [19:0] tmr_ff;
  logic status_ff;
  logic rel_ff;
  logic rd_bit_ff;
  logic [15:0] out_sr_ff;
  logic [4:0] out_cnt_ff;
  logic [10:0] rd_addr_ff;
  logic so_ff;
  logic so_en_ff;
  logic [4:0] addr_w;
  logic [4:0] data_w;
  logic [4:0] hdr_len;
  logic [4:0] nxt_cnt;
  logic [10:0] nxt_addr;
  logic [15:0] nxt_data;
  logic [1:0] prefix;
  logic [10:0] amask;
  logic [10:0] wa;
  logic [15:0] word_at;
  logic [10:0] byte_base;
  logic start;
  assign addr_w = x16 ? `SECI_ADDR_W16 : `SECI_ADDR_W8;
  assign data_w = x16 ? `SECI_DATA_W16 : `SECI_DATA_W8;
  assign hdr_len = 5'h02 + addr_w;
  assign nxt_cnt = cnt_ff + 5'h01;
  assign nxt_addr = {addr_ff[9:0], si_s} & amask;
  assign nxt_data = x16 ? {data_ff[14:0], si_s} : {8'h00, data_ff[6:0], si_s};
  assign prefix = x16 ? nxt_addr[9:8] : nxt_addr[10:9];
  assign amask = x16 ? `SECI_MASK_X16 : `SECI_MASK_X8;
  assign wa = (st_ff == SECI_D_READ) ? ((rd_addr_ff + 11'h001) & amask)
                                     : nxt_addr;
  assign word_at = x16 ? {mem[{wa[9:0], 1'h0}], mem[{wa[9:0], 1'h1}]}
                       : {mem[wa], 8'h00};
  assign byte_base = x16 ? {addr_ff[9:0], 1'h0} : addr_ff;
  assign start = cs_fall & (st_ff == SECI_D_HOLD) & pend_ff & prog_en_ff
                 & pe_s;
  ////////////////////////////////////////////////////////////////////////
  // frame receiver
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= SECI_D_IDLE;
      cnt_ff <= 5'h00;
      opc_ff <= 2'h0;
      addr_ff <= 11'h000;
      data_ff <= 16'h0000;
      pend_ff <= 1'h0;
      pend_all_ff <= 1'h0;
      pend_data_ff <= 16'h0000;
      prog_en_ff <= 1'h0;
    end else if (cs_fall) begin
      st_ff <= SECI_D_IDLE;
      pend_ff <= 1'h0;
    end else if (sk_rise && cs_s) begin
      unique case (st_ff)
        SECI_D_IDLE: begin
          if (si_s == `SECI_START_BIT && !busy_ff) begin
            st_ff <= SECI_D_SHIFT;
            cnt_ff <= 5'h00;
          end
        end
        SECI_D_SHIFT: begin
          cnt_ff <= nxt_cnt;
          if (cnt_ff < 5'h02) begin
            opc_ff <= {opc_ff[0], si_s};
          end else if (cnt_ff < hdr_len) begin
            addr_ff <= nxt_addr;
          end else begin
            data_ff <= nxt_data;
          end
          if (nxt_cnt == hdr_len) begin
            unique case (opc_ff)
              `SECI_OPC_READ: st_ff <= SECI_D_READ;
              `SECI_OPC_ERASE: begin
                st_ff <= SECI_D_HOLD;
                pend_ff <= 1'h1;
                pend_all_ff <= 1'h0;
                pend_data_ff <= `SECI_ERASED;
              end
              `SECI_OPC_WRITE: st_ff <= SECI_D_SHIFT;
              default: begin
                unique case (prefix)
                  `SECI_SUB_UNLOCK: begin
                    prog_en_ff <= 1'h1;
                    st_ff <= SECI_D_HOLD;
                  end
                  `SECI_SUB_LOCK: begin
                    prog_en_ff <= 1'h0;
                    st_ff <= SECI_D_HOLD;
                  end
                  `SECI_SUB_CLEAR: begin
                    st_ff <= SECI_D_HOLD;
                    pend_ff <= 1'h1;
                    pend_all_ff <= 1'h1;
                    pend_data_ff <= `SECI_ERASED;
                  end
                  default: st_ff <= SECI_D_SHIFT;
                endcase
              end
            endcase
          end else if (nxt_cnt == hdr_len + data_w) begin
            st_ff <= SECI_D_HOLD;
            pend_ff <= 1'h1;
            pend_all_ff <= (opc_ff == `SECI_OPC_MISC);
            pend_data_ff <= x16 ? nxt_data
                                : {nxt_data[7:0], nxt_data[7:0]};
          end
        end
        default: begin
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // self-timed cycle and array update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_ff <= 1'h0;
      walk_ff <= 1'h0;
      walk_ff_idx <= 11'h000;
      tmr_ff <= 20'h00000;
    end else if (start) begin
      busy_ff <= 1'h1;
      walk_ff <= pend_all_ff;
      walk_ff_idx <= 11'h000;
      tmr_ff <= 20'(CYCLE_MAX_CYC - 1);
    end else begin
      if (tmr_ff != 20'h00000) begin
        tmr_ff <= tmr_ff - 20'h00001;
      end
      if (walk_ff) begin
        walk_ff_idx <= walk_ff_idx + 11'h001;
        if (walk_ff_idx == `SECI_LAST_BYTE) begin
          walk_ff <= 1'h0;
        end
      end
      if (busy_ff && tmr_ff == 20'h00000 && !walk_ff) begin
        busy_ff <= 1'h0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (start && !pend_all_ff) begin
      mem[byte_base] <= x16 ? pend_data_ff[15:8] : pend_data_ff[7:0];
      if (x16) begin
        mem[byte_base + 11'h001] <= pend_data_ff[7:0];
      end
    end else if (walk_ff) begin
      mem[walk_ff_idx] <= (walk_ff_idx[0] || !x16) ? pend_data_ff[7:0]
                                                   : pend_data_ff[15:8];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read shifter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_bit_ff <= 1'h0;
      out_sr_ff <= 16'h0000;
      out_cnt_ff <= 5'h00;
      rd_addr_ff <= 11'h000;
    end else if (sk_rise && cs_s) begin
      if (st_ff == SECI_D_SHIFT && nxt_cnt == hdr_len
          && opc_ff == `SECI_OPC_READ) begin
        rd_bit_ff <= 1'h0;
        out_sr_ff <= word_at;
        out_cnt_ff <= 5'h00;
        rd_addr_ff <= nxt_addr;
      end else if (st_ff == SECI_D_READ) begin
        rd_bit_ff <= out_sr_ff[15];
        if (out_cnt_ff == data_w - 5'h01) begin
          out_cnt_ff <= 5'h00;
          rd_addr_ff <= wa;
          out_sr_ff <= word_at;
        end else begin
          out_cnt_ff <= out_cnt_ff + 5'h01;
          out_sr_ff <= {out_sr_ff[14:0], 1'h0};
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // status report and output drive
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_ff <= 1'h0;
      rel_ff <= 1'h0;
    end else if (start) begin
      status_ff <= 1'h1;
      rel_ff <= 1'h0;
    end else if (rel_ff && sk_fall) begin
      status_ff <= 1'h0;
      rel_ff <= 1'h0;
    end else if (status_ff && sk_rise && cs_s && si_s) begin
      rel_ff <= 1'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      so_ff <= 1'h0;
      so_en_ff <= 1'h0;
    end else begin
      so_ff <= (st_ff == SECI_D_READ) ? rd_bit_ff : ~busy_ff;
      so_en_ff <= cs_s & ((st_ff == SECI_D_READ) | status_ff);
    end
  end
  assign link.serial_out = so_ff;
  assign link.serial_out_en = so_en_ff;
  assign busy = busy_ff;
  assign program_enabled = prog_en_ff;
endmodule : seci_device

// *** seci_regs.svh ***
// constants of the serial memory command link
`ifndef SECI_REGS_SVH
`define SECI_REGS_SVH
`define SECI_START_BIT 1'h1
`define SECI_OPC_READ 2'h2
`define SECI_OPC_ERASE 2'h3
`define SECI_OPC_WRITE 2'h1
`define SECI_OPC_MISC 2'h0
`define SECI_SUB_UNLOCK 2'h3
`define SECI_SUB_LOCK 2'h0
`define SECI_SUB_CLEAR 2'h2
`define SECI_SUB_FILL 2'h1
`define SECI_ADDR_W16 5'h0a
`define SECI_ADDR_W8 5'h0b
`define SECI_DATA_W16 5'h10
`define SECI_DATA_W8 5'h08
`define SECI_MASK_X16 11'h3ff
`define SECI_MASK_X8 11'h7ff
`define SECI_LAST_BYTE 11'h7ff
`define SECI_ERASED 16'hffff
`define SECI_CLK_NS 8
`define SECI_CYCLE_MAX_MS 5
`define SECI_POWERUP_MS 1
`define SECI_MAX_RATE_KHZ 3000
`define SECI_CS_MIN_LOW_NS 150
`define SECI_POLL_SETTLE 5'h08
`endif

// *** seci_pkg.sv ***
// types shared by both ends of the serial memory link
package seci_pkg;
  typedef enum logic [2:0] {
    SECI_CMD_READ = 3'h0,
    SECI_CMD_ERASE = 3'h1,
    SECI_CMD_WRITE = 3'h2,
    SECI_CMD_UNLOCK = 3'h3,
    SECI_CMD_LOCK = 3'h4,
    SECI_CMD_CLEAR = 3'h5,
    SECI_CMD_FILL = 3'h6
  } seci_cmd_t;
  typedef enum logic [3:0] {
    SECI_D_IDLE = 4'h1,
    SECI_D_SHIFT = 4'h2,
    SECI_D_READ = 4'h4,
    SECI_D_HOLD = 4'h8
  } seci_dev_st_t;
  typedef enum logic [5:0] {
    SECI_H_IDLE = 6'h01,
    SECI_H_SEND = 6'h02,
    SECI_H_READ = 6'h04,
    SECI_H_GAP = 6'h08,
    SECI_H_POLL = 6'h10,
    SECI_H_REL = 6'h20
  } seci_host_st_t;
endpackage : seci_pkg

// *** seci_link_if.sv ***
// four-wire serial link between host and memory device
`timescale 1ns/10ps
interface seci_link_if;
  logic chip_select;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_en;
  wire serial_line;
  // released line idles high, as under a pull-up
  assign serial_line = serial_out_en ? serial_out : 1'b1;
  modport dev (
    input chip_select,
    input serial_clock,
    input serial_in,
    output serial_out,
    output serial_out_en
  );
  modport host (
    output chip_select,
    output serial_clock,
    output serial_in,
    input serial_line
  );
endinterface : seci_link_if

// *** seci_host.sv ***
// host end: frames commands, reads words, polls status
`timescale 1ns/10ps
`include "seci_regs.svh"
module seci_host import seci_pkg::*; #(
  parameter int POWERUP_CYC =
    (`SECI_POWERUP_MS * 1000000 + `SECI_CLK_NS - 1) / `SECI_CLK_NS,
  parameter int HALF_CYC = (1000000 + 2 * `SECI_MAX_RATE_KHZ *
    `SECI_CLK_NS - 1) / (2 * `SECI_MAX_RATE_KHZ * `SECI_CLK_NS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  seci_link_if.host link,
  // organization in use
  input wire logic x16,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire seci_cmd_t cmd_op,
  input wire logic [10:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  // answer
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  localparam int GAP_CYC =
    (`SECI_CS_MIN_LOW_NS + `SECI_CLK_NS - 1) / `SECI_CLK_NS;
  ////////////////////////////////////////////////////////////////////////
  seci_host_st_t st_ff;
  logic [16:0] pu_ff;
  logic [7:0] div_ff;
  logic tick;
  logic so1_ff;
  logic so2_ff;
  logic cs_ff;
  logic sk_ff;
  logic si_ff;
  logic [29:0] tx_ff;
  logic [4:0] len_ff;
  logic [4:0] bit_ff;
  logic [16:0] rx_ff;
  logic is_read_ff;
  logic poll_ff;
  logic [4:0] gap_ff;
  logic [1:0] opc;
  logic [1:0] sub;
  logic has_data;
  logic [29:0] frame;
  assign cmd_ready = (st_ff == SECI_H_IDLE) && (pu_ff == 17'h00000);
  assign tick = (div_ff == 8'(HALF_CYC - 1));
  always_comb begin
    opc = `SECI_OPC_MISC;
    sub = `SECI_SUB_LOCK;
    has_data = 1'h0;
    unique case (cmd_op)
      SECI_CMD_READ: opc = `SECI_OPC_READ;
      SECI_CMD_ERASE: opc = `SECI_OPC_ERASE;
      SECI_CMD_WRITE: begin
        opc = `SECI_OPC_WRITE;
        has_data = 1'h1;
      end
      SECI_CMD_UNLOCK: sub = `SECI_SUB_UNLOCK;
      SECI_CMD_CLEAR: sub = `SECI_SUB_CLEAR;
      SECI_CMD_FILL: begin
        sub = `SECI_SUB_FILL;
        has_data = 1'h1;
      end
      default: sub = `SECI_SUB_LOCK;
    endcase
    if (x16) begin
      frame = {`SECI_START_BIT, opc,
               (opc == `SECI_OPC_MISC) ? {sub, 8'h00} : cmd_addr[9:0],
               cmd_data, 1'h0};
    end else begin
      frame = {`SECI_START_BIT, opc,
               (opc == `SECI_OPC_MISC) ? {sub, 9'h000} : cmd_addr,
               cmd_data[7:0], 8'h00};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pu_ff <= 17'(POWERUP_CYC);
      div_ff <= 8'h00;
      so1_ff <= 1'h0;
      so2_ff <= 1'h0;
    end else begin
      if (pu_ff != 17'h00000) begin
        pu_ff <= pu_ff - 17'h00001;
      end
      div_ff <= (tick || st_ff == SECI_H_IDLE) ? 8'h00 : div_ff + 8'h01;
      so1_ff <= link.serial_line;
      so2_ff <= so1_ff;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= SECI_H_IDLE;
      cs_ff <= 1'h0;
      sk_ff <= 1'h0;
      si_ff <= 1'h0;
      tx_ff <= 30'h00000000;
      len_ff <= 5'h00;
      bit_ff <= 5'h00;
      rx_ff <= 17'h00000;
      is_read_ff <= 1'h0;
      poll_ff <= 1'h0;
      gap_ff <= 5'h00;
      rsp_valid <= 1'h0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'h0;
      unique case (st_ff)
        SECI_H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            st_ff <= SECI_H_SEND;
            cs_ff <= 1'h1;
            si_ff <= frame[29];
            tx_ff <= {frame[28:0], 1'h0};
            len_ff <= 5'h03 + (x16 ? `SECI_ADDR_W16 : `SECI_ADDR_W8)
                      + (has_data ? (x16 ? `SECI_DATA_W16
                                         : `SECI_DATA_W8) : 5'h00);
            bit_ff <= 5'h00;
            is_read_ff <= (cmd_op == SECI_CMD_READ);
            poll_ff <= (cmd_op != SECI_CMD_UNLOCK)
                       && (cmd_op != SECI_CMD_LOCK)
                       && (cmd_op != SECI_CMD_READ);
          end
        end
        SECI_H_SEND: begin
          if (tick) begin
            sk_ff <= ~sk_ff;
            if (!sk_ff) begin
              bit_ff <= bit_ff + 5'h01;
            end else if (bit_ff == len_ff) begin
              bit_ff <= 5'h00;
              si_ff <= 1'h0;
              st_ff <= is_read_ff ? SECI_H_READ : SECI_H_GAP;
              cs_ff <= is_read_ff;
              gap_ff <= 5'h00;
            end else begin
              si_ff <= tx_ff[29];
              tx_ff <= {tx_ff[28:0], 1'h0};
            end
          end
        end
        SECI_H_READ: begin
          if (tick) begin
            sk_ff <= ~sk_ff;
            if (sk_ff) begin
              rx_ff <= {rx_ff[15:0], so2_ff};
              bit_ff <= bit_ff + 5'h01;
              // dummy 0 stood before the first data rise, so no skip
              if (bit_ff + 5'h01 == (x16 ? `SECI_DATA_W16
                                         : `SECI_DATA_W8)) begin
                rsp_data <= x16 ? {rx_ff[14:0], so2_ff}
                                : {8'h00, rx_ff[6:0], so2_ff};
                cs_ff <= 1'h0;
                st_ff <= SECI_H_GAP;
                gap_ff <= 5'h00;
              end
            end
          end
        end
        SECI_H_GAP: begin
          gap_ff <= gap_ff + 5'h01;
          if (gap_ff == 5'(GAP_CYC)) begin
            gap_ff <= 5'h00;
            if (poll_ff) begin
              cs_ff <= 1'h1;
              st_ff <= SECI_H_POLL;
            end else begin
              rsp_valid <= 1'h1;
              st_ff <= SECI_H_IDLE;
            end
          end
        end
        SECI_H_POLL: begin
          if (gap_ff != `SECI_POLL_SETTLE) begin
            gap_ff <= gap_ff + 5'h01;
          end else if (so2_ff) begin
            si_ff <= 1'h1;
            st_ff <= SECI_H_REL;
          end
        end
        default: begin
          if (tick) begin
            sk_ff <= ~sk_ff;
            if (sk_ff) begin
              cs_ff <= 1'h0;
              si_ff <= 1'h0;
              poll_ff <= 1'h0;
              gap_ff <= 5'h00;
              st_ff <= SECI_H_GAP;
            end
          end
        end
      endcase
    end
  end
  assign link.chip_select = cs_ff;
  assign link.serial_clock = sk_ff;
  assign link.serial_in = si_ff;
endmodule : seci_host

// *** seci_link_asserts.sv ***
// concurrent checks on the link between host and device ends
`timescale 1ns/10ps
module seci_link_asserts #(
  parameter int HALF_CYC = 21
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  logic sk_ff;
  logic first_ff;
  logic [5:0] rise_ff;
  logic [7:0] half_ff;
  logic sk_rise;
  assign sk_rise = serial_clock && !sk_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    sk_ff <= nrst & serial_clock;
  end
  // first rise of a selected frame
  always_ff @(posedge clk) begin
    first_ff <= !nrst || !chip_select || (first_ff && !sk_rise);
  end
  // rises counted within one frame
  always_ff @(posedge clk) begin
    if (!nrst || !chip_select)
      rise_ff <= 6'h00;
    else if (sk_rise)
      rise_ff <= rise_ff + 6'h01;
  end
  // cycles since the last clock level change
  always_ff @(posedge clk) begin
    if (!nrst || serial_clock != sk_ff)
      half_ff <= 8'h00;
    else if (half_ff != 8'hff)
      half_ff <= half_ff + 8'h01;
  end
  //////////////////////////////////////////////////////////////////////
  chk_out_floats: assert property (
    (!chip_select)[*6] |-> !serial_out_en)
    else $error("output driven while deselected");
  chk_lead_zero: assert property (
    $rose(serial_out_en) |-> !serial_out)
    else $error("output enabled with a high first bit");
  chk_release_low: assert property (
    $fell(serial_out_en) |-> !serial_clock || !chip_select)
    else $error("output released while clock high");
  chk_data_on_rise: assert property (
    serial_out_en && $past(serial_out_en) && $fell(serial_out)
      |-> serial_clock)
    else $error("read data changed off a rising edge");
  chk_in_stable: assert property (
    sk_rise |-> $stable(serial_in)[*4])
    else $error("serial input moved around a rising edge");
  chk_start_one: assert property (
    sk_rise && chip_select && first_ff |-> serial_in)
    else $error("frame began without a start bit");
  chk_frame_len: assert property (
    $fell(chip_select) |-> rise_ff inside
      {6'h01, 6'h0d, 6'h0e, 6'h16, 6'h17, 6'h1d, 6'h1e})
    else $error("frame length not a legal count");
  chk_half_period: assert property (
    serial_clock != sk_ff |-> half_ff >= HALF_CYC - 1)
    else $error("serial clock phase too short");
endmodule : seci_link_asserts

// *** serial_eeprom_cmd_interface_tb.sv ***
// self-checking bench: host end and device end joined over the link
`timescale 1ns/10ps
module serial_eeprom_cmd_interface_tb import seci_pkg::*;;
  localparam int CYC = 2100;
  localparam int PWR = 20;
  localparam int HALF = 21;
  logic clk;
  logic nrst;
  logic word_width_strap;
  logic program_allow_pin;
  logic busy;
  logic program_enabled;
  logic x16;
  logic cmd_valid;
  logic cmd_ready;
  seci_cmd_t cmd_op;
  logic [10:0] cmd_addr;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [7:0] mem [0:2047];
  logic unlk;
  int num_errors;
  int num_checks;
  int busy_len;
  integer seed;
  //////////////////////////////////////////////////////////////////////
  seci_link_if seci_link_if_i ();
  seci_device #(.CYCLE_MAX_CYC(CYC)) seci_device_i (
    .clk(clk), .nrst(nrst), .link(seci_link_if_i.dev),
    .word_width_strap(word_width_strap),
    .program_allow_pin(program_allow_pin),
    .busy(busy), .program_enabled(program_enabled));
  seci_host #(.POWERUP_CYC(PWR), .HALF_CYC(HALF)) seci_host_i (
    .clk(clk), .nrst(nrst), .link(seci_link_if_i.host), .x16(x16),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  seci_link_asserts #(.HALF_CYC(HALF)) seci_link_asserts_i (
    .clk(clk), .nrst(nrst),
    .chip_select(seci_link_if_i.chip_select),
    .serial_clock(seci_link_if_i.serial_clock),
    .serial_in(seci_link_if_i.serial_in),
    .serial_out(seci_link_if_i.serial_out),
    .serial_out_en(seci_link_if_i.serial_out_en));
  //////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (busy === 1'b1)
      busy_len <= busy_len + 1;
  end
  initial begin
    // full scenario list needs about 70k cycles
    repeat (90000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // x16 word a is bytes 2a (high) and 2a+1 (low)
  function automatic logic [15:0] exp_rd(input logic [10:0] a);
    logic [10:0] b;
    b = {a[9:0], 1'b0};
    exp_rd = x16 ? {mem[b], mem[b + 11'h1]} : {8'h00, mem[a]};
  endfunction : exp_rd
  // entered and left just after a rising edge
  task automatic do_cmd(input seci_cmd_t op, input logic [10:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    busy_len = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("handshake", {15'h0, n >= 20000}, 16'h0);
  endtask : do_cmd
  task automatic run(input seci_cmd_t op, input logic [10:0] a,
                     input logic [15:0] d);
    logic ok;
    logic prog;
    logic [10:0] b;
    ok = unlk & program_allow_pin;
    prog = op inside {SECI_CMD_WRITE, SECI_CMD_ERASE, SECI_CMD_CLEAR,
                      SECI_CMD_FILL};
    b = x16 ? {a[9:0], 1'b0} : a;
    do_cmd(op, a, d);
    if (op == SECI_CMD_UNLOCK)
      unlk = 1'b1;
    if (op == SECI_CMD_LOCK)
      unlk = 1'b0;
    check("lock", {15'h0, program_enabled}, {15'h0, unlk});
    if (op == SECI_CMD_READ)
      check("read", rsp_data, exp_rd(a));
    if (ok && op inside {SECI_CMD_WRITE, SECI_CMD_ERASE}) begin
      mem[b] = (op == SECI_CMD_ERASE) ? 8'hff : (x16 ? d[15:8] : d[7:0]);
      if (x16)
        mem[b + 11'h1] = (op == SECI_CMD_ERASE) ? 8'hff : d[7:0];
    end
    for (int i = 0; i < 2048; i++) begin
      if (ok && op inside {SECI_CMD_CLEAR, SECI_CMD_FILL})
        mem[i] = (op == SECI_CMD_CLEAR) ? 8'hff :
                 ((x16 && !i[0]) ? d[15:8] : d[7:0]);
    end
    if (prog)
      check("busy", {15'h0, busy_len > 0 && busy_len <= CYC},
            {15'h0, ok});
  endtask : run
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [10:0] a;
    logic [10:0] lim;
    logic [15:0] d;
    clk = 1'b0;
    nrst = 1'b0;
    word_width_strap = 1'b1;
    x16 = 1'b1;
    program_allow_pin = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = SECI_CMD_READ;
    cmd_addr = 11'h000;
    cmd_data = 16'h0000;
    unlk = 1'b0;
    seed = 46606;
    repeat (10) @(posedge clk);
    #1;
    check("rst_drive", {15'h0, seci_link_if_i.serial_out_en}, 16'h0);
    check("rst_lock", {15'h0, program_enabled}, 16'h0);
    nrst = 1'b1;
    repeat (PWR - 4) @(posedge clk);
    #1;
    check("early", {15'h0, cmd_ready}, 16'h0);
    run(SECI_CMD_WRITE, 11'h005, 16'h1234);
    for (int m = 0; m < 2; m++) begin
      x16 = (m == 0);
      word_width_strap = x16;
      lim = x16 ? 11'h3ff : 11'h7ff;
      run(SECI_CMD_UNLOCK, 11'h000, 16'h0000);
      run(SECI_CMD_CLEAR, 11'h000, 16'h0000);
      run(SECI_CMD_READ, lim, 16'h0000);
      for (int i = 0; i < 2; i++) begin
        a = 11'($random(seed)) & lim;
        d = 16'($random(seed));
        run(SECI_CMD_WRITE, a, d);
        run(SECI_CMD_WRITE, (a + 11'h1) & lim, ~d);
        run(SECI_CMD_READ, a, 16'h0000);
      end
      run(SECI_CMD_ERASE, a, 16'h0000);
      run(SECI_CMD_READ, a, 16'h0000);
      run(SECI_CMD_FILL, 11'h000, d);
      // enable survives a low allow pin, programs do not
      program_allow_pin = 1'b0;
      run(SECI_CMD_LOCK, 11'h000, 16'h0000);
      run(SECI_CMD_UNLOCK, 11'h000, 16'h0000);
      run(SECI_CMD_WRITE, a, ~d);
      program_allow_pin = 1'b1;
      run(SECI_CMD_LOCK, 11'h000, 16'h0000);
      run(SECI_CMD_WRITE, lim, ~d);
      run(SECI_CMD_READ, lim, 16'h0000);
      run(SECI_CMD_READ, a, 16'h0000);
    end
    x16 = 1'b1;
    word_width_strap = 1'b1;
    run(SECI_CMD_READ, a >> 1, 16'h0000);
    complete_run();
  end
endmodule : serial_eeprom_cmd_interface_tb
